/* dbg_link_pkg.sv */
/*
  Constants, command codes and types shared by both ends of the serial
  debug link. Assumes a single core clock of 125 MHz on both ends.
*/
// Function
// [RL1] Two-wire: clock pin reserved, its function lost
// [RL2] One-wire: data pin only, clock pin unused
// [RL3] No trace, RAM monitor or hot attach
// [RL4] Fast oscillator forced on while link active
// [RL5] Software keeps oscillator powered in user boot
// [RL6] Oscillator change spoils access; probe slows rate
// [RL7] Debug only at or above minimum clock
// [RL8] Held pin reset released by the probe
// [RL9] Pin reset clears performance and trace data; code clears only with serial link in use outside single-chip mode, or during an access
// [RL10] Scan port, user boot: internal reset loses control
// [RL11] Scan port, external mode: control resumes after restore
// [RL12] No internal resets while serial link used
// [RL13] Stepped or breakpointed software reset is suppressed
// [RL14] No software reset while serial link used
// [RL15] Reset during access: timeout, reinit, session continues
package dbg_link_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CMD_W = 4;   // Command field width
  localparam int RSP_W = 4;   // Status reply width
  localparam int BT_W  = 12;  // Bit time counter width

  // ----------------------------------------------------------------
  // Commands from probe to device
  // ----------------------------------------------------------------
  localparam logic [CMD_W-1:0] CMD_STATUS  = 4'h0;
  localparam logic [CMD_W-1:0] CMD_HALT    = 4'h1;
  localparam logic [CMD_W-1:0] CMD_RUN     = 4'h2;
  localparam logic [CMD_W-1:0] CMD_STEP    = 4'h3;
  localparam logic [CMD_W-1:0] CMD_REL_RST = 4'h4;
  localparam logic [CMD_W-1:0] CMD_MEM     = 4'h5;

  // ----------------------------------------------------------------
  // Reply bit positions
  // ----------------------------------------------------------------
  localparam int RSP_HALTED  = 0;
  localparam int RSP_IN_RST  = 1;
  localparam int RSP_MEM_BAD = 2;
  localparam int RSP_TMO     = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [BT_W-1:0] BIT_CYC_FAST = 12'h010; // Start bit time
  localparam int TURN_SH      = 1;   // Turnaround is 2**1 bit times
  localparam int REPLY_TMO_SH = 3;   // Reply wait is 2**3 bit times
  localparam logic [3:0] GUARD_CYC = 4'h4; // Covers synchroniser lag
  localparam real MIN_DBG_KHZ = 32.768;
  localparam real CORE_CLK_MHZ = 125.0;
  localparam real CORE_CLK_KHZ = CORE_CLK_MHZ * 1000.0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic HALTED_RST  = 1'b0;
  localparam logic CPU_RST_RST = 1'b0;
  localparam logic OE_N_RST    = 1'b1;

  // Operating mode of the core
  typedef enum logic [1:0] {BOOT_SINGLE, BOOT_USER, BOOT_EXT_NOROM} boot_mode_t;

endpackage : dbg_link_pkg

/* dbg_link_if.sv */
/*
  Pins of the debug link: clock pin and open-drain mode/data pin.
  Assumes a weak pull-up on the data pin and a pull-down on the clock.
*/
interface dbg_link_if;

  logic pclk;       // Probe clock pin drive value
  logic pclk_oe_n;  // Probe clock pin enable, low drives
  logic pd_o;       // Probe data drive value
  logic pd_oe_n;    // Probe data enable, low drives
  logic dd_o;       // Device data drive value
  logic dd_oe_n;    // Device data enable, low drives
  logic pclk_pin;   // Resolved clock pin level
  logic dat;        // Resolved data pin level

  // Undriven clock pin is pulled low
  assign pclk_pin = pclk_oe_n ? 1'b0 : pclk;
  // Wired-and data pin with pull-up
  assign dat = !((!pd_oe_n && !pd_o) || (!dd_oe_n && !dd_o));

  modport probe (output pclk, output pclk_oe_n, output pd_o, output pd_oe_n, input dat);
  modport dev (input pclk_pin, input dat, output dd_o, output dd_oe_n);

endinterface : dbg_link_if

/* sync2.sv */
/*
  Two-flop synchroniser for pin levels.
  Assumes levels change slowly relative to the core clock.
*/
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;  // First stage, read only by second

  // ----------------------------------------------------------------
  // Two stages
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_q <= '1;
      q      <= '1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : sync2

/* dbg_link_dev.sv */
/*
  Device end of the serial debug link: receives probe commands, answers
  with status, and manages reset, oscillator and pin reservation.
  Assumes core-side inputs are on core_clk; pin_rst_n is a raw pin.
*/
module dbg_link_dev #(
  parameter bit  TWO_WIRE = 1'b0,
  parameter real CORE_KHZ = dbg_link_pkg::CORE_CLK_KHZ
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  dbg_link_if.dev                      link,
  input  wire logic                    probe_present,
  input  wire logic                    jtag_sel,
  input  wire dbg_link_pkg::boot_mode_t boot_mode,
  input  wire logic                    pin_rst_n,
  input  wire logic                    wdt_rst,
  input  wire logic                    int_rst,
  input  wire logic                    sw_rst_req,
  input  wire logic                    step_active,
  input  wire logic                    bp_at_pc,
  input  wire logic                    mode_restored,
  input  wire logic                    sw_osc_en,
  input  wire logic                    osc_freq_chg,
  input  wire logic                    mem_ack,
  output logic                         osc_run,
  output logic                         clk_pin_func_en,
  output logic                         link_active,
  output logic                         ctrl_lost,
  output logic                         cpu_rst,
  output logic                         cpu_halt,
  output logic                         cpu_step,
  output logic                         mem_req,
  output logic                         perf_trace_clr,
  output logic                         sw_rst_go
);

  localparam int CW = dbg_link_pkg::BT_W + 1;  // Cycle counter width

  // Receive and reply sequencer states
  typedef enum logic [2:0] {S_IDLE, S_MEAS, S_RX, S_TURN, S_TX, S_LOST} dev_state_t;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic pclk_s;       // Clock pin, synchronised
  logic dat_s;        // Data pin, synchronised
  logic pin_rst_n_s;  // Reset pin, synchronised
  logic pclk_d_q;     // Previous clock pin level

  sync2 #(.W(3)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        ({link.pclk_pin, link.dat, pin_rst_n}),
    .q        ({pclk_s, dat_s, pin_rst_n_s})
  );

  // ----------------------------------------------------------------
  // Attach: decided once after reset
  // ----------------------------------------------------------------
  localparam bit CLK_OK = CORE_KHZ >= dbg_link_pkg::MIN_DBG_KHZ;
  logic init_q;     // Attach decision taken
  logic link_en_q;  // Probe accepted for this power-up

  // A probe arriving later is ignored, so no hot attach
  always_ff @(posedge core_clk) begin
    if (rst) begin
      init_q    <= 1'b0;
      link_en_q <= 1'b0;
    end else if (!init_q) begin
      init_q    <= 1'b1;
      link_en_q <= probe_present & CLK_OK;  // [RL3] [RL7]
    end
  end

  // ----------------------------------------------------------------
  // Pin reservation and oscillator
  // ----------------------------------------------------------------
  wire serial_on = link_en_q & !jtag_sel;  // Serial link in use
  // Link timing rides on the fast oscillator, whatever software says
  assign osc_run         = sw_osc_en | serial_on;      // [RL4]
  assign clk_pin_func_en = !(serial_on & TWO_WIRE);    // [RL1]
  assign link_active     = serial_on;
  // No trace port or RAM monitor path exists on this link

  // ----------------------------------------------------------------
  // Reset events
  // ----------------------------------------------------------------
  logic pin_rst_q;   // Reset pin seen last cycle
  logic cpu_rst_q;   // Core held in reset
  logic halted_q;    // Core halted by probe
  logic mem_pend_q;  // Memory access outstanding
  logic mem_bad_q;   // Access spoiled by oscillator change
  logic tmo_q;       // Access ended by reset
  logic lost_q;      // Probe control lost
  logic clr_q;       // Performance and trace clear pulse
  logic step_q;      // Single step pulse
  logic swr_q;       // Software reset pulse

  wire pin_rst    = !pin_rst_n_s;
  wire pin_rise   = pin_rst & !pin_rst_q;
  wire not_single = boot_mode != dbg_link_pkg::BOOT_SINGLE;
  wire ext_mode   = boot_mode == dbg_link_pkg::BOOT_EXT_NOROM;
  wire hold_rel   = serial_on | (jtag_sel & not_single);  // [RL8]
  wire rst_evt    = pin_rise | wdt_rst;
  wire int_any    = wdt_rst | int_rst;
  wire sw_rst_ok  = sw_rst_req & !(jtag_sel & (step_active | bp_at_pc));  // [RL13]
  // Serial link cannot survive internal or software reset
  wire lose_ser   = serial_on & (int_any | sw_rst_ok);  // [RL12] [RL14]
  wire lose_scan  = jtag_sel & int_any & not_single;   // [RL10] [RL11]
  wire regain     = jtag_sel & ext_mode & mode_restored & !cpu_rst_q;  // [RL11]
  wire clr_d      = (pin_rise & serial_on & not_single) | (rst_evt & mem_pend_q);  // [RL9] [RL15]

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  dev_state_t      st_q, st_d;
  logic [CW-1:0]   cnt_q, cnt_d;
  logic [CW-1:0]   tgt_q, tgt_d;
  logic [dbg_link_pkg::BT_W-1:0] bt_q, bt_d;
  logic [2:0]      bit_q, bit_d;
  logic [3:0]      sh_q, sh_d;
  logic [4:0]      tx_q, tx_d;
  logic            oe_n_q, oe_n_d;

  wire             pclk_rise = pclk_s & !pclk_d_q;
  // Two-wire samples on the probe clock; one-wire on its own timer
  wire             tick   = TWO_WIRE ? pclk_rise : (cnt_q == tgt_q);  // [RL1] [RL2]
  wire [3:0]       cmd_now = {dat_s, sh_q[3:1]};
  wire             do_cmd = (st_q == S_RX) & tick & (bit_q == 3'h3);
  wire [CW-1:0]    bt_w   = {1'b0, bt_q};
  wire             turn_done = (st_q == S_TURN) & (cnt_q == CW'(bt_w << dbg_link_pkg::TURN_SH));
  wire             rpt    = turn_done;
  wire [3:0]       rsp_now = {tmo_q, mem_bad_q, cpu_rst_q, halted_q};
  wire             is_halt = do_cmd & (cmd_now == dbg_link_pkg::CMD_HALT);
  wire             is_run  = do_cmd & (cmd_now == dbg_link_pkg::CMD_RUN);
  wire             is_step = do_cmd & (cmd_now == dbg_link_pkg::CMD_STEP);
  wire             is_rel  = do_cmd & (cmd_now == dbg_link_pkg::CMD_REL_RST);
  wire             is_mem  = do_cmd & (cmd_now == dbg_link_pkg::CMD_MEM);

  // ----------------------------------------------------------------
  // Core control state
  // ----------------------------------------------------------------
  // With serial link or non-single-chip scan port, reset hold is released by the probe, not by the pin
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_rst_q <= 1'b0;
      cpu_rst_q <= dbg_link_pkg::CPU_RST_RST;
    end else begin
      pin_rst_q <= pin_rst;
      cpu_rst_q <= pin_rst | (cpu_rst_q & hold_rel & !is_rel);  // [RL8]
    end
  end

  // Reset during an access stops the program and reports timeout
  always_ff @(posedge core_clk) begin
    if (rst) begin
      halted_q   <= dbg_link_pkg::HALTED_RST;
      mem_pend_q <= 1'b0;
    end else begin
      if (rst_evt & mem_pend_q) begin
        halted_q   <= 1'b1;  // [RL15]
        mem_pend_q <= 1'b0;
      end else begin
        halted_q   <= is_halt | (halted_q & !is_run);
        mem_pend_q <= is_mem | (mem_pend_q & !mem_ack);
      end
    end
  end

  // Sticky flags; a new event beats the clear from a reply
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mem_bad_q <= 1'b0;
      tmo_q     <= 1'b0;
      lost_q    <= 1'b0;
    end else begin
      mem_bad_q <= (mem_pend_q & osc_freq_chg) | (mem_bad_q & !rpt);  // [RL6]
      tmo_q     <= (mem_pend_q & rst_evt) | (tmo_q & !rpt);  // [RL15]
      lost_q    <= lose_ser | lose_scan | (lost_q & !regain);
    end
  end

  // One-cycle pulses toward the core
  always_ff @(posedge core_clk) begin
    if (rst) begin
      clr_q  <= 1'b0;
      step_q <= 1'b0;
      swr_q  <= 1'b0;
    end else begin
      clr_q  <= clr_d;
      step_q <= is_step;
      swr_q  <= sw_rst_ok;
    end
  end

  // ----------------------------------------------------------------
  // Link sequencer, next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d   = st_q;
    cnt_d  = (&cnt_q) ? cnt_q : cnt_q + 1'b1;
    tgt_d  = tgt_q;
    bt_d   = bt_q;
    bit_d  = bit_q;
    sh_d   = sh_q;
    tx_d   = tx_q;
    oe_n_d = oe_n_q;
    case (st_q)
      S_IDLE: begin
        // Guard time keeps our own last bit from looking like a start
        if (serial_on & !dat_s & (cnt_q >= CW'(dbg_link_pkg::GUARD_CYC))) begin
          st_d  = S_MEAS;
          cnt_d = '0;
        end
      end
      S_MEAS: begin
        // Start bit length sets the bit time
        if (dat_s) begin
          bt_d  = cnt_q[dbg_link_pkg::BT_W-1:0] + 1'b1;
          tgt_d = cnt_q + (cnt_q >> 1);
          cnt_d = '0;
          bit_d = '0;
          st_d  = S_RX;
        end else if (cnt_q[CW-1]) begin
          st_d = S_IDLE;
        end
      end
      S_RX: begin
        if (tick) begin
          sh_d  = cmd_now;
          cnt_d = '0;
          tgt_d = bt_w - 1'b1;
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'h3) begin
            st_d = S_TURN;
          end
        end
      end
      S_TURN: begin
        if (turn_done) begin
          st_d   = S_TX;
          tx_d   = {rsp_now, 1'b0};
          oe_n_d = 1'b0;
          cnt_d  = '0;
          bit_d  = '0;
        end
      end
      S_TX: begin
        // Start bit, then four status bits, low bit first
        if (cnt_q == bt_w - 1'b1) begin
          cnt_d  = '0;
          tx_d   = {1'b1, tx_q[4:1]};
          oe_n_d = tx_q[1];
          bit_d  = bit_q + 3'h1;
          if (bit_q == 3'h4) begin
            st_d   = S_IDLE;
            oe_n_d = 1'b1;
          end
        end
      end
      S_LOST: begin
        cnt_d = '0;
        if (!lost_q) begin
          st_d = S_IDLE;
        end
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
    // Losing control silences the link at once
    if (lost_q & (st_q != S_LOST)) begin
      st_d   = S_LOST;  // [RL10] [RL12] [RL14]
      oe_n_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Link sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q     <= S_IDLE;
      cnt_q    <= '0;
      tgt_q    <= '0;
      bt_q     <= dbg_link_pkg::BIT_CYC_FAST;
      bit_q    <= '0;
      sh_q     <= '0;
      tx_q     <= '1;
      oe_n_q   <= dbg_link_pkg::OE_N_RST;
      pclk_d_q <= 1'b1;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      tgt_q    <= tgt_d;
      bt_q     <= bt_d;
      bit_q    <= bit_d;
      sh_q     <= sh_d;
      tx_q     <= tx_d;
      oe_n_q   <= oe_n_d;
      pclk_d_q <= pclk_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.dd_o      = 1'b0;  // Open drain: only ever pulls low
  assign link.dd_oe_n   = oe_n_q;
  assign ctrl_lost      = lost_q;
  assign cpu_rst        = cpu_rst_q;
  assign cpu_halt       = halted_q;
  assign cpu_step       = step_q;
  assign mem_req        = mem_pend_q;
  assign perf_trace_clr = clr_q;
  assign sw_rst_go      = swr_q;

endmodule : dbg_link_dev

/* dbg_link_probe.sv */
/*
  Probe end of the serial debug link: sends commands, collects the
  status reply, slows the bit rate on link errors.
  Assumes the user side is on core_clk; data pin is asynchronous.
*/
module dbg_link_probe #(
  parameter bit TWO_WIRE = 1'b0,
  parameter logic [dbg_link_pkg::BT_W-1:0] BIT_CYC = dbg_link_pkg::BIT_CYC_FAST
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  dbg_link_if.probe       link,
  input  wire logic       cmd_valid,
  input  wire logic [3:0] cmd,
  output logic            cmd_ready,
  output logic            rsp_valid,
  output logic [3:0]      rsp,
  output logic            link_err,
  output logic            reinit,
  output logic            rate_low,
  output logic            reset_held
);

  localparam int CW = dbg_link_pkg::BT_W + 4;  // Cycle counter width
  localparam int BW = dbg_link_pkg::BT_W;

  // Transfer states
  typedef enum logic [1:0] {H_IDLE, H_TX, H_WAIT, H_RX} probe_state_t;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  probe_state_t  st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;    // Cycle counter
  logic [CW-1:0] tgt_q, tgt_d;    // Next sample point
  logic [BW-1:0] bt_q, bt_d;      // Current bit time
  logic [2:0]    bit_q, bit_d;    // Bit index
  logic [5:0]    sh_q, sh_d;      // Outgoing frame
  logic [3:0]    rx_q, rx_d;      // Incoming status
  logic          oe_n_q, oe_n_d;  // Data pin enable
  logic          pclk_q, pclk_d;  // Clock pin level
  logic          rv_q, rv_d;      // Reply pulse
  logic          err_q, err_d;    // Link error pulse
  logic          ri_q, ri_d;      // Reinit pulse
  logic [3:0]    rsp_q, rsp_d;    // Last reply
  logic          dat_s;           // Data pin, synchronised

  sync2 #(.W(1)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        (link.dat),
    .q        (dat_s)
  );

  wire [CW-1:0] bt_w = {4'h0, bt_q};
  wire [3:0]    rx_now = {dat_s, rx_q[3:1]};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q + 1'b1;
    tgt_d  = tgt_q;
    bt_d   = bt_q;
    bit_d  = bit_q;
    sh_d   = sh_q;
    rx_d   = rx_q;
    oe_n_d = oe_n_q;
    pclk_d = 1'b0;
    rv_d   = 1'b0;
    err_d  = 1'b0;
    ri_d   = 1'b0;
    rsp_d  = rsp_q;
    case (st_q)
      H_IDLE: begin
        // Frame: start low, sync high, four command bits
        if (cmd_valid & cmd_ready) begin
          sh_d   = {cmd, 1'b1, 1'b0};
          oe_n_d = 1'b0;
          cnt_d  = '0;
          bit_d  = '0;
          st_d   = H_TX;
        end
      end
      H_TX: begin
        // Two-wire: clock rises mid data bit for the device to sample
        pclk_d = TWO_WIRE & (bit_q >= 3'h2) & (cnt_q >= (bt_w >> 1));  // [RL1]
        if (cnt_q == bt_w - 1'b1) begin
          cnt_d  = '0;
          sh_d   = {1'b1, sh_q[5:1]};
          oe_n_d = sh_q[1];
          bit_d  = bit_q + 3'h1;
          if (bit_q == 3'h5) begin
            oe_n_d = 1'b1;
            pclk_d = 1'b0;
            st_d   = H_WAIT;
          end
        end
      end
      H_WAIT: begin
        if (!dat_s & (cnt_q >= CW'(dbg_link_pkg::GUARD_CYC))) begin
          cnt_d = '0;
          tgt_d = bt_w + (bt_w >> 1);
          bit_d = '0;
          st_d  = H_RX;
        end else if (cnt_q == CW'(bt_w << dbg_link_pkg::REPLY_TMO_SH)) begin
          // No answer: halve the bit rate and let the user retry
          err_d = 1'b1;  // [RL6]
          bt_d  = bt_q[BW-1] ? bt_q : {bt_q[BW-2:0], 1'b0};  // [RL6]
          st_d  = H_IDLE;
        end
      end
      H_RX: begin
        if (cnt_q == tgt_q) begin
          rx_d  = rx_now;
          cnt_d = '0;
          tgt_d = bt_w - 1'b1;
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'h3) begin
            rv_d  = 1'b1;
            rsp_d = rx_now;
            st_d  = H_IDLE;
            // Reset during access: restart link state, keep the session
            if (rx_now[dbg_link_pkg::RSP_TMO]) begin
              ri_d = 1'b1;  // [RL15]
              bt_d = BIT_CYC;
            end
          end
        end
      end
      default: begin
        st_d = H_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q   <= H_IDLE;
      cnt_q  <= '0;
      tgt_q  <= '0;
      bt_q   <= BIT_CYC;
      bit_q  <= '0;
      sh_q   <= '1;
      rx_q   <= '0;
      oe_n_q <= dbg_link_pkg::OE_N_RST;
      pclk_q <= 1'b0;
      rv_q   <= 1'b0;
      err_q  <= 1'b0;
      ri_q   <= 1'b0;
      rsp_q  <= '0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      tgt_q  <= tgt_d;
      bt_q   <= bt_d;
      bit_q  <= bit_d;
      sh_q   <= sh_d;
      rx_q   <= rx_d;
      oe_n_q <= oe_n_d;
      pclk_q <= pclk_d;
      rv_q   <= rv_d;
      err_q  <= err_d;
      ri_q   <= ri_d;
      rsp_q  <= rsp_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.pclk      = pclk_q;
  assign link.pclk_oe_n = !TWO_WIRE;  // [RL2]
  assign link.pd_o      = 1'b0;
  assign link.pd_oe_n   = oe_n_q;
  assign cmd_ready      = (st_q == H_IDLE) & dat_s & (cnt_q >= bt_w);
  assign rsp_valid      = rv_q;
  assign rsp            = rsp_q;
  assign link_err       = err_q;
  assign reinit         = ri_q;
  assign rate_low       = bt_q != BIT_CYC;
  assign reset_held     = rsp_q[dbg_link_pkg::RSP_IN_RST];  // [RL8]

endmodule : dbg_link_probe

/* dbg_link_assertions.sv */
/*
  Checker for the one-wire debug link pins between the two ends.
  Assumes one core clock, synchronous active-high reset, 16-cycle bits.
*/
module dbg_link_assertions (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pclk_oe_n,
  input wire logic pclk_pin,
  input wire logic pd_oe_n,
  input wire logic pd_o,
  input wire logic dd_o,
  input wire logic dd_oe_n
);
  // ------------------------------------------------------------
  // Pin rules
  // ------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Clock pin is never driven in the one-wire build
  AST_CLK_UNUSED: assert property (pclk_oe_n && !pclk_pin)
    else $error("clock pin driven");
  // Device only pulls the shared pin low
  AST_DEV_OPEN_DRAIN: assert property (!dd_oe_n |-> !dd_o)
    else $error("device drives data high");
  // Never both ends pulling at once
  AST_NO_CLASH: assert property (!(!dd_oe_n && !pd_oe_n))
    else $error("both ends drive data");
  // Probe only pulls the pin low
  AST_PROBE_OPEN_DRAIN: assert property (!pd_oe_n |-> !pd_o)
    else $error("probe drives data high");
  // A probe low bit lasts at least most of one bit time
  AST_PROBE_BIT: assert property ($fell(pd_oe_n) |-> !pd_oe_n[*8] ##1 !pd_oe_n[*7])
    else $error("probe low bit too short");
  // A device low bit lasts at least half a bit time
  AST_DEV_BIT: assert property ($fell(dd_oe_n) |-> !dd_oe_n[*8])
    else $error("device low bit too short");
endmodule : dbg_link_assertions

/* mcu_debug_link_reset_clock_rules_tb.sv */
/*
  Testbench joining probe and device ends over the link interface.
  Assumes the package constants and a 125 MHz core clock.
*/
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module mcu_debug_link_reset_clock_rules_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic core_clk = 0, rst = 1, cmd_valid = 0, cmd_ready, rsp_valid, link_err;
  logic [3:0] cmd = 4'h0, rsp;
  logic jtag_sel = 0, pin_rst_n = 1, sw_rst_req = 0, step_active = 0, bp_at_pc = 0;
  logic osc_run, clk_pin_func_en, cpu_rst, cpu_halt, perf_trace_clr, sw_rst_go, seen;
  logic sw_osc_en = 0, osc_freq_chg = 0;
  dbg_link_pkg::boot_mode_t boot_mode = dbg_link_pkg::BOOT_SINGLE;
  int fail_count = 0, n_checks = 0, halted_m = 0, seed = 32'hB9A1, k;
  logic [3:0] q[$];  // Commands still to send
  always #4 core_clk = ~core_clk;
  dbg_link_if link_i ();
  dbg_link_dev dbg_link_dev_i (.core_clk(core_clk), .rst(rst), .link(link_i),
    .probe_present(1'b1), .jtag_sel(jtag_sel), .boot_mode(boot_mode),
    .pin_rst_n(pin_rst_n), .wdt_rst(1'b0), .int_rst(1'b0), .sw_rst_req(sw_rst_req),
    .step_active(step_active), .bp_at_pc(bp_at_pc), .mode_restored(1'b0),
    .sw_osc_en(sw_osc_en), .osc_freq_chg(osc_freq_chg), .mem_ack(1'b0), .osc_run(osc_run),
    .clk_pin_func_en(clk_pin_func_en), .link_active(), .ctrl_lost(), .cpu_rst(cpu_rst),
    .cpu_halt(cpu_halt), .cpu_step(), .mem_req(), .perf_trace_clr(perf_trace_clr),
    .sw_rst_go(sw_rst_go));
  dbg_link_probe dbg_link_probe_i (.core_clk(core_clk), .rst(rst), .link(link_i),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp(rsp), .link_err(link_err), .reinit(), .rate_low(), .reset_held());
  dbg_link_assertions chk_i (.core_clk(core_clk), .rst(rst), .pclk_oe_n(link_i.pclk_oe_n),
    .pclk_pin(link_i.pclk_pin), .pd_oe_n(link_i.pd_oe_n), .dd_o(link_i.dd_o),
    .dd_oe_n(link_i.dd_oe_n), .pd_o(link_i.pd_o));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // Send one command, wait for its reply under a bound
  task automatic send(input logic [3:0] c);
    @(negedge core_clk);
    cmd_valid = 1;
    cmd = c;
    while (cmd_ready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    cmd_valid = 0;
    for (k = 0; k < 3000 && rsp_valid !== 1'b1 && link_err !== 1'b1; k++) @(negedge core_clk);
    if (k == 3000) fail_count++;
  endtask : send
  // Watchdog cuts a hang short
  initial begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    end_of_test;
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(negedge core_clk);
    rst = 0;
    repeat (6) @(negedge core_clk);
    // Random halt, run and step traffic vs the model
    repeat (6) q.push_back(4'(dbg_link_pkg::CMD_HALT + $unsigned($random(seed)) % 3));
    while (q.size() > 0) begin
      cmd = q.pop_front();
      if (cmd == dbg_link_pkg::CMD_HALT) halted_m = 1;
      if (cmd == dbg_link_pkg::CMD_RUN) halted_m = 0;
      {sw_osc_en, osc_freq_chg} = 2'($random(seed));
      send(cmd);
      `CHK("cpu_halt", halted_m[0], cpu_halt)
      `CHK("rsp", halted_m[0], rsp[0])
      `CHK("osc_run", 1'b1, osc_run)
      `CHK("clk_pin_func_en", 1'b1, clk_pin_func_en)
    end
    $display("test traffic done");
    // Pin reset on serial link: clear, hold till probe release
    sw_osc_en = 1;
    boot_mode = dbg_link_pkg::BOOT_USER;
    pin_rst_n = 0;
    seen = 0;
    repeat (8) @(negedge core_clk) seen |= perf_trace_clr;
    `CHK("perf_trace_clr", 1'b1, seen)
    @(negedge core_clk);
    pin_rst_n = 1;
    repeat (8) @(negedge core_clk);
    `CHK("cpu_rst held", 1'b1, cpu_rst)
    send(dbg_link_pkg::CMD_REL_RST);
    repeat (2) @(negedge core_clk);
    `CHK("cpu_rst released", 1'b0, cpu_rst)
    $display("test pin reset done");
    // Scan port software reset: suppressed when stepped or breakpointed
    jtag_sel = 1;
    for (int i = 0; i < 3; i++) begin
      step_active = (i == 0);
      bp_at_pc = (i == 1);
      sw_rst_req = 1;
      @(negedge core_clk);
      sw_rst_req = 0;
      `CHK("sw_rst_go", (i == 2), sw_rst_go)
      @(negedge core_clk);
    end
    $display("test software reset done");
    end_of_test;
  end
endmodule : mcu_debug_link_reset_clock_rules_tb
